// *** hw/prt_map.svh ***
// register offsets, field positions and reset values of the proximity threshold block
// assumes an 8-bit register address space as seen by the two-wire host interface
`ifndef PRT_MAP_SVH
`define PRT_MAP_SVH
`define PRT_ADDR_RESULT_HI    8'h87
`define PRT_ADDR_RESULT_LO    8'h88
`define PRT_ADDR_IRQ_CTRL     8'h89
`define PRT_ADDR_LOWTH_HI     8'h8A
`define PRT_ADDR_LOWTH_LO     8'h8B
`define PRT_ADDR_HIGHTH_HI    8'h8C
`define PRT_ADDR_HIGHTH_LO    8'h8D
`define PRT_ADDR_IRQ_STATUS   8'h8E
`define PRT_CTRL_COUNT_MSB    7
`define PRT_CTRL_COUNT_LSB    5
`define PRT_CTRL_READY_EN     3
`define PRT_CTRL_THRES_EN     1
`define PRT_CTRL_THRES_SEL    0
`define PRT_STAT_ABOVE_HIGH   0
`define PRT_STAT_BELOW_LOW    1
`define PRT_STAT_READY        3
`define PRT_CTRL_RESET        8'h00
`define PRT_THRESH_RESET      16'h0000
`define PRT_CTRL_WMASK        8'hEB
`define PRT_STAT_MASK         8'h0B
`endif

// *** hw/prt_pkg.sv ***
// types shared by the proximity threshold block
// offsets and fields live in prt_map.svh
package prt_pkg;
  // one host register access
  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    logic [7:0] addr;
    logic [7:0] wdata;
  } prt_regreq_t;

  // one finished measurement from the sequencer
  typedef struct packed {
    logic        valid;
    logic [15:0] value;
  } prt_meas_t;
endpackage

// *** hw/prt_run_counter.sv ***
// consecutive out-of-band measurement counter
// assumes one step pulse per measurement; counts restart from zero on reaching the selected target
`timescale 1ns/1ps
`include "prt_map.svh"
module prt_run_counter (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       clkEn,
  input  wire logic       step,
  input  wire logic       outOfBand,
  input  wire logic [2:0] countCode,
  output logic            reached
);
  logic [7:0] run_q;
  logic [7:0] run_d;
  logic [7:0] target;
  logic       reached_d;

  // code n selects 2**n measurements; an in-band one restarts the run
  always_comb begin
    target    = 8'h01 << countCode;
    run_d     = run_q;
    reached_d = 1'b0;
    if (step) begin
      if (!outOfBand) begin
        run_d = 8'h00;
      end else if (run_q + 8'h01 >= target) begin
        reached_d = 1'b1;
        run_d     = 8'h00; // rearm so a further full run is needed
      end else begin
        run_d = run_q + 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_q   <= 8'h00;
      reached <= 1'b0;
    end else if (clkEn) begin
      run_q   <= run_d;
      reached <= reached_d;
    end
  end
endmodule

// *** hw/prt_threshold_irq.sv ***
// proximity result, threshold comparison and interrupt status registers
// assumes a host register port already decoded from the two-wire bus, read data
// taken one cycle after rdEn, and one meas.valid pulse per finished measurement
// What this block does
// - result is one unsigned 16-bit value
// - result high byte 87h, low 88h
// - result bytes read-only, host writes ignored
// - control 89h: count, ready, threshold enables
// - interrupt after 1..128 coded consecutive exceeds
// - threshold enable gates threshold interrupts
// - source select 0 compares proximity results
// - low threshold at 8Ah/8Bh, read/write
// - high threshold at 8Ch/8Dh, read/write
// - status sticky until host writes one
// - interrupt pad low while status set
// - status 8Eh: high bit0, low bit1, ready bit3
`timescale 1ns/1ps
`include "prt_map.svh"
module prt_threshold_irq (
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  input  wire logic                clkEn,
  input  wire prt_pkg::prt_regreq_t regReq,
  input  wire prt_pkg::prt_meas_t   meas,
  output logic [7:0]               rdData,
  output logic                     irq_n
);
  logic [15:0] result_q;
  logic [15:0] result_d;
  logic [7:0]  ctrl_q;
  logic [7:0]  ctrl_d;
  logic [15:0] lowTh_q;
  logic [15:0] lowTh_d;
  logic [15:0] highTh_q;
  logic [15:0] highTh_d;
  logic [7:0]  status_q;
  logic [7:0]  status_d;
  logic [7:0]  rdData_d;
  logic        irq_n_d;
  logic        aboveHigh;
  logic        belowLow;
  logic        outOfBand;
  logic        runReached;
  logic        measStep_q;
  logic        measStep_d;
  logic        above_q;
  logic        above_d;
  logic        below_q;
  logic        below_d;
  logic [7:0]  clearMask;

  // compare the arriving sample; only proximity source exists, so sel=1 compares nothing
  always_comb begin
    aboveHigh = meas.value > highTh_q;
    belowLow  = meas.value < lowTh_q;
    outOfBand = (aboveHigh | belowLow) &
                !ctrl_q[`PRT_CTRL_THRES_SEL];
  end

  // the counter's reached flag lands one cycle after the sample, so remember which side was crossed
  always_comb begin
    measStep_d = meas.valid;
    above_d    = above_q;
    below_d    = below_q;
    if (meas.valid) begin
      above_d = aboveHigh & !ctrl_q[`PRT_CTRL_THRES_SEL];
      below_d = belowLow & !ctrl_q[`PRT_CTRL_THRES_SEL];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      measStep_q <= 1'b0;
      above_q    <= 1'b0;
      below_q    <= 1'b0;
    end else if (clkEn) begin
      measStep_q <= measStep_d;
      above_q    <= above_d;
      below_q    <= below_d;
    end
  end

  prt_run_counter u_run (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .clkEn     (clkEn),
    .step      (meas.valid),
    .outOfBand (outOfBand),
    .countCode (ctrl_q[`PRT_CTRL_COUNT_MSB:`PRT_CTRL_COUNT_LSB]),
    .reached   (runReached)
  );

  // host writes; result bytes have no write path at all
  always_comb begin
    result_d = result_q;
    ctrl_d   = ctrl_q;
    lowTh_d  = lowTh_q;
    highTh_d = highTh_q;
    if (meas.valid) begin
      result_d = meas.value;
    end
    if (regReq.wrEn) begin
      unique case (regReq.addr)
        `PRT_ADDR_IRQ_CTRL:   ctrl_d = regReq.wdata & `PRT_CTRL_WMASK;
        `PRT_ADDR_LOWTH_HI:   lowTh_d[15:8] = regReq.wdata;
        `PRT_ADDR_LOWTH_LO:   lowTh_d[7:0] = regReq.wdata;
        `PRT_ADDR_HIGHTH_HI:  highTh_d[15:8] = regReq.wdata;
        `PRT_ADDR_HIGHTH_LO:  highTh_d[7:0] = regReq.wdata;
        default:              ctrl_d = ctrl_q;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      result_q <= 16'h0000;
      ctrl_q   <= `PRT_CTRL_RESET;
      lowTh_q  <= `PRT_THRESH_RESET;
      highTh_q <= `PRT_THRESH_RESET;
    end else if (clkEn) begin
      result_q <= result_d;
      ctrl_q   <= ctrl_d;
      lowTh_q  <= lowTh_d;
      highTh_q <= highTh_d;
    end
  end

  // sticky status: write-one-to-clear, a new event in the same cycle wins
  always_comb begin
    clearMask = 8'h00;
    if (regReq.wrEn && regReq.addr == `PRT_ADDR_IRQ_STATUS) begin
      clearMask = regReq.wdata & `PRT_STAT_MASK;
    end
    status_d = status_q & ~clearMask;
    if (runReached && measStep_q && ctrl_q[`PRT_CTRL_THRES_EN]) begin
      status_d[`PRT_STAT_ABOVE_HIGH] = status_d[`PRT_STAT_ABOVE_HIGH] | above_q;
      status_d[`PRT_STAT_BELOW_LOW]  = status_d[`PRT_STAT_BELOW_LOW] | below_q;
    end
    if (meas.valid && ctrl_q[`PRT_CTRL_READY_EN]) begin
      status_d[`PRT_STAT_READY] = 1'b1;
    end
    irq_n_d = !(|status_d);
  end

  // read mux, registered; unmapped addresses read zero
  always_comb begin
    rdData_d = rdData;
    if (regReq.rdEn) begin
      unique case (regReq.addr)
        `PRT_ADDR_RESULT_HI:  rdData_d = result_q[15:8];
        `PRT_ADDR_RESULT_LO:  rdData_d = result_q[7:0];
        `PRT_ADDR_IRQ_CTRL:   rdData_d = ctrl_q;
        `PRT_ADDR_LOWTH_HI:   rdData_d = lowTh_q[15:8];
        `PRT_ADDR_LOWTH_LO:   rdData_d = lowTh_q[7:0];
        `PRT_ADDR_HIGHTH_HI:  rdData_d = highTh_q[15:8];
        `PRT_ADDR_HIGHTH_LO:  rdData_d = highTh_q[7:0];
        `PRT_ADDR_IRQ_STATUS: rdData_d = status_q;
        default:              rdData_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= 8'h00;
      rdData   <= 8'h00;
      irq_n    <= 1'b1;
    end else if (clkEn) begin
      status_q <= status_d;
      rdData   <= rdData_d;
      irq_n    <= irq_n_d;
    end
  end
endmodule

// *** tb/prt_sva.sv ***
// assertions on the ports of the proximity threshold block
// assumes it is bound to prt_threshold_irq with clkEn kept high
`timescale 1ns/1ps
module prt_sva (
  input wire logic                 core_clk,
  input wire logic                 rst_n,
  input wire logic                 clkEn,
  input wire prt_pkg::prt_regreq_t regReq,
  input wire prt_pkg::prt_meas_t   meas,
  input wire logic [7:0]           rdData,
  input wire logic                 irq_n
);
  logic [7:0] ctl_q;
  logic [7:0] hi_q;
  logic       wr;
  logic       rd;
  assign wr = clkEn && regReq.wrEn;
  assign rd = clkEn && regReq.rdEn;
  // shadow of host writes to control and, to stay small, only the upper high-threshold byte
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_q <= 8'h00;
      hi_q  <= 8'h00;
    end else if (wr && regReq.addr == 8'h89) begin
      ctl_q <= regReq.wdata;
    end else if (wr && regReq.addr == 8'h8C) begin
      hi_q <= regReq.wdata;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // a count-of-one run above the high threshold, proximity as source
  sequence sExceed;
    clkEn && meas.valid && ctl_q[7:5] == 3'h0 && ctl_q[1:0] == 2'b10 && meas.value[15:8] > hi_q;
  endsequence
  a_ready_irq: assert property (clkEn && meas.valid && ctl_q[3] |-> ##[1:2] !irq_n)
    else $error("ready event left pad high");
  a_thresh_irq: assert property (sExceed |-> ##[1:3] !irq_n)
    else $error("threshold event left pad high");
  a_irq_hold: assert property (!irq_n && !(wr && regReq.addr == 8'h8E) |=> !irq_n)
    else $error("pad released without a clear");
  a_zero_keeps: assert property (!irq_n && wr && regReq.addr == 8'h8E && regReq.wdata == 8'h00
    |=> !irq_n)
    else $error("writing zero cleared status");
  a_release_cause: assert property ($rose(irq_n) |-> $past(wr) && $past(regReq.addr) == 8'h8E)
    else $error("pad rose with no status write");
  a_ctrl_read: assert property (rd && regReq.addr == 8'h89 |=> rdData == (ctl_q & 8'hEB))
    else $error("control readback wrong");
  a_high_read: assert property (rd && regReq.addr == 8'h8C |=> rdData == hi_q)
    else $error("high threshold readback wrong");
  a_stat_spare: assert property (rd && regReq.addr == 8'h8E |=> (rdData & 8'hF4) == 8'h00)
    else $error("spare status bits set");
endmodule
bind prt_threshold_irq prt_sva sva_u (.core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn),
  .regReq(regReq), .meas(meas), .rdData(rdData), .irq_n(irq_n));

// *** tb/prt_host.sv ***
// host model: register writes and reads on the decoded register port
// assumes the bench calls wr and rd hierarchically, one at a time
`timescale 1ns/1ps
module prt_host (
  input  wire logic           core_clk,
  input  wire logic [7:0]     rdData,
  output prt_pkg::prt_regreq_t regReq
);
  initial regReq = '{1'b0, 1'b0, 8'h00, 8'h00};
  // idle bus shows inverted values so a stale address never passes for a live one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk) regReq <= '{1'b1, 1'b0, a, d};
    @(posedge core_clk) regReq <= '{1'b0, 1'b0, ~a, ~d};
  endtask
  // read data is registered, so it is taken just after the edge that took the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk) regReq <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge core_clk) regReq <= '{1'b0, 1'b0, ~a, 8'hFF};
    #1 d = rdData;
  endtask
endmodule

// *** tb/prt_threshold_irq_bench.sv ***
// self-checking bench for the proximity threshold block
// assumes prt_host drives the register port and this module the measurements
`timescale 1ns/1ps
module prt_threshold_irq_bench;
  logic                 core_clk = 1'b0;
  logic                 rst_n = 1'b0;
  logic                 clkEn = 1'b1;
  prt_pkg::prt_regreq_t regReq;
  prt_pkg::prt_meas_t   meas = '{1'b0, 16'h0000};
  logic [7:0]           rdData;
  logic [7:0]           got;
  logic                 irq_n;
  logic [7:0]           th [4] = '{8'h01, 8'h55, 8'h02, 8'hAA};
  int                   errors = 0;
  int                   cmp_count = 0;
  always #10 core_clk = ~core_clk;
  prt_host host_u (.core_clk(core_clk), .rdData(rdData), .regReq(regReq));
  prt_threshold_irq dut_u (.core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn), .regReq(regReq),
    .meas(meas), .rdData(rdData), .irq_n(irq_n));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host_u.rd(a, got);
    chk(got, e);
  endtask
  // pad is registered alongside status, from status_d, so two edges give it ample room to land
  task automatic ichk(input logic e);
    repeat (2) @(posedge core_clk);
    #1 chk({7'h00, irq_n}, {7'h00, e});
  endtask
  task automatic meas1(input logic [15:0] v);
    @(posedge core_clk) meas <= '{1'b1, v};
    @(posedge core_clk) meas.valid <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
  // control reset value, spare control bits, unmapped read, threshold bytes
  task automatic t_regs;
    rchk(8'h89, 8'h00);
    rchk(8'h80, 8'h00);
    host_u.wr(8'h89, 8'hFF);
    rchk(8'h89, 8'hEB);
    for (int i = 0; i < 4; i++) begin
      host_u.wr(8'(8'h8A + i), th[i]);
      rchk(8'(8'h8A + i), th[i]);
    end
  endtask
  // result pair, read-only high byte, data-ready status and its clear
  task automatic t_result;
    host_u.wr(8'h89, 8'h08);
    meas1(16'h1234);
    ichk(1'b0);
    rchk(8'h87, 8'h12);
    rchk(8'h88, 8'h34);
    host_u.wr(8'h87, 8'h00);
    rchk(8'h87, 8'h12);
    rchk(8'h8E, 8'h08);
    host_u.wr(8'h8E, 8'h00);
    ichk(1'b0);
    host_u.wr(8'h8E, 8'h08);
    ichk(1'b1);
  endtask
  // every count code: one short stays quiet, the full run fires
  task automatic t_count;
    host_u.wr(8'h89, 8'h02);
    meas1(16'h0200);
    for (int c = 0; c < 8; c++) begin
      host_u.wr(8'h89, {3'(c), 5'h02});
      for (int n = 1; n < (1 << c); n++) meas1(16'h0300);
      rchk(8'h8E, 8'h00);
      meas1(16'h0300);
      rchk(8'h8E, 8'h01);
      host_u.wr(8'h8E, 8'h01);
    end
  endtask
  // an in-band result restarts the run; disabled threshold stays silent
  task automatic t_band;
    host_u.wr(8'h89, 8'h22);
    meas1(16'h0100);
    meas1(16'h0200);
    meas1(16'h0100);
    rchk(8'h8E, 8'h00);
    meas1(16'h0100);
    rchk(8'h8E, 8'h02);
    host_u.wr(8'h89, 8'h20);
    host_u.wr(8'h8E, 8'h02);
    meas1(16'h0100);
    meas1(16'h0100);
    rchk(8'h8E, 8'h00);
    // source select set: no comparison, so a full run stays silent
    host_u.wr(8'h89, 8'h23);
    meas1(16'h0100);
    meas1(16'h0100);
    rchk(8'h8E, 8'h00);
    // clock enable low: a measurement offered then must not land
    @(posedge core_clk) clkEn <= 1'b0;
    meas1(16'h4321);
    @(posedge core_clk) clkEn <= 1'b1;
    rchk(8'h87, 8'h01);
  endtask
  task automatic print_verdict;
    $display("checks=%0d errors=%0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    t_regs;
    t_result;
    t_count;
    t_band;
    print_verdict;
  end
  // the whole run needs some 1500 cycles; this cuts a hang well after that
  initial begin
    #1_000_000;
    errors++;
    print_verdict;
  end
endmodule
